// ### logic/link_status_pkg.sv
// Register map, field layout and bus constants of the link and error status bank.
package link_status_pkg;

  // ----------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_DEVICE_ERROR_STATUS = 10'h04a;
  localparam logic [9:0] IDX_LINK_CAPABILITIES = 10'h04c;
  localparam logic [9:0] IDX_LINK_CONTROL = 10'h050;
  localparam logic [9:0] IDX_LINK_STATUS = 10'h052;

  // ----------------------------------------------------------------
  // Field positions and hardwired values.
  // ----------------------------------------------------------------
  localparam int ERR_LSB = 0;
  localparam int ERR_WIDTH = 4;
  localparam logic [3:0] ERR_RESET = 4'h0;
  localparam int PM_CTRL_LSB = 0;
  localparam logic [1:0] PM_CTRL_RESET = 2'h0;
  localparam int COMMON_CLOCK_BIT = 6;
  localparam int EXT_SYNC_BIT = 7;
  localparam logic [3:0] SPEED_CODE = 4'h1;
  localparam logic [5:0] WIDTH_CODE = 6'h08;
  localparam logic [1:0] POWER_MGMT_SUPPORT = 2'h1;
  localparam logic [2:0] L0S_EXIT_LATENCY = 3'h0;
  localparam logic [2:0] L1_EXIT_LATENCY = 3'h0;
  localparam logic [7:0] PORT_NUMBER = 8'h00;

  // ----------------------------------------------------------------
  // Bus encodings.
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef struct packed {
    logic correctable;
    logic nonfatal;
    logic fatal;
    logic unsupported;
  } err_event_t;

  typedef struct packed {
    logic [3:0] err_flags;
    logic [1:0] pm_ctrl;
    logic common_clock_cfg;
    logic extended_sync;
    logic pending;
    logic pending_write;
    logic [9:0] pending_idx;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } bank_state_t;

endpackage : link_status_pkg

// ### logic/link_status_regs.sv
// AHB-Lite register bank for device error status and virtual link registers.
//
// Operation
// - Correctable error sets bit 0; write one clears.
// - Non-fatal error sets bit 1; write one clears.
// - Fatal error sets bit 2; write one clears.
// - Unsupported request sets bit 3; write one clears.
// - Aux power detected bit reads zero.
// - Transactions pending bit reads zero.
// - Maximum speed code hardwired to one.
// - Maximum width code hardwired to eight.
// - L0s entry support advertised; power management support code one.
// - L0s exit latency field reads zero.
// - L1 exit latency field reads zero.
// - Port number reads zero.
// - Two-bit power control field, read-write, resets zero.
// - Read completion boundary bit reads zero.
// - Link disable and retrain read zero.
// - Common clock and sync bits stored only.
// - Current speed code hardwired to one.
// - Current width code hardwired to eight.
// - Training error and training bits read zero.
// - Slot clock bit reads zero.
module link_status_regs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire link_status_pkg::err_event_t err_event,
  output logic [3:0] err_flags,
  output logic [1:0] pm_ctrl
);

  // ----------------------------------------------------------------
  // Read assembly.
  // ----------------------------------------------------------------
  // Every fixed field is built from constants, so bits not placed here read zero.
  function automatic logic [31:0] read_word(input link_status_pkg::bank_state_t st,
                                            input logic [9:0] idx);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (idx)
      link_status_pkg::IDX_DEVICE_ERROR_STATUS: begin
        // Aux power and pending bits stay zero above the flags.
        w[link_status_pkg::ERR_LSB +: link_status_pkg::ERR_WIDTH] = st.err_flags;
      end
      link_status_pkg::IDX_LINK_CAPABILITIES: begin
        w[3:0] = link_status_pkg::SPEED_CODE;
        w[9:4] = link_status_pkg::WIDTH_CODE;
        w[11:10] = link_status_pkg::POWER_MGMT_SUPPORT;
        w[14:12] = link_status_pkg::L0S_EXIT_LATENCY;
        w[17:15] = link_status_pkg::L1_EXIT_LATENCY;
        w[31:24] = link_status_pkg::PORT_NUMBER;
      end
      link_status_pkg::IDX_LINK_CONTROL: begin
        // Completion boundary, disable and retrain bits remain zero.
        w[link_status_pkg::PM_CTRL_LSB +: 2] = st.pm_ctrl;
        w[link_status_pkg::COMMON_CLOCK_BIT] = st.common_clock_cfg;
        w[link_status_pkg::EXT_SYNC_BIT] = st.extended_sync;
      end
      link_status_pkg::IDX_LINK_STATUS: begin
        // Training and slot clock bits remain zero.
        w[3:0] = link_status_pkg::SPEED_CODE;
        w[9:4] = link_status_pkg::WIDTH_CODE;
      end
      default: begin
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  link_status_pkg::bank_state_t state_r;
  link_status_pkg::bank_state_t state_nxt;
  logic [3:0] raised;
  logic [3:0] cleared;

  assign raised = {err_event.unsupported, err_event.fatal, err_event.nonfatal,
                   err_event.correctable};

  // Each transfer takes one wait state. Applying writes and sampling reads in
  // the same late edge keeps a read right after a write from returning stale data.
  always_comb begin
    state_nxt = state_r;
    cleared = 4'h0;
    state_nxt.hresp = link_status_pkg::HRESP_OKAY;
    if (state_r.pending) begin
      if (state_r.pending_write) begin
        // Only the documented writable bits take data; the rest is dropped.
        case (state_r.pending_idx)
          link_status_pkg::IDX_DEVICE_ERROR_STATUS: begin
            cleared = hwdata[link_status_pkg::ERR_LSB +: link_status_pkg::ERR_WIDTH];
          end
          link_status_pkg::IDX_LINK_CONTROL: begin
            state_nxt.pm_ctrl = hwdata[link_status_pkg::PM_CTRL_LSB +: 2];
            state_nxt.common_clock_cfg = hwdata[link_status_pkg::COMMON_CLOCK_BIT];
            state_nxt.extended_sync = hwdata[link_status_pkg::EXT_SYNC_BIT];
          end
          default: begin
            cleared = 4'h0;
          end
        endcase
      end else begin
        state_nxt.hrdata = read_word(state_r, state_r.pending_idx);
      end
      state_nxt.pending = 1'b0;
      state_nxt.hreadyout = 1'b1;
    end else if (hsel && hready && htrans == link_status_pkg::HTRANS_NONSEQ) begin
      state_nxt.pending = 1'b1;
      state_nxt.pending_write = hwrite;
      state_nxt.pending_idx = haddr[11:2];
      state_nxt.hreadyout = 1'b0;
    end
    // A one clears, a zero keeps, and a new event in the same cycle wins.
    state_nxt.err_flags = (state_r.err_flags & ~cleared) | raised;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r.err_flags <= link_status_pkg::ERR_RESET;
      state_r.pm_ctrl <= link_status_pkg::PM_CTRL_RESET;
      state_r.common_clock_cfg <= 1'b0;
      state_r.extended_sync <= 1'b0;
      state_r.pending <= 1'b0;
      state_r.pending_write <= 1'b0;
      state_r.pending_idx <= 10'h000;
      state_r.hreadyout <= 1'b1;
      state_r.hresp <= link_status_pkg::HRESP_OKAY;
      state_r.hrdata <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------
  assign hreadyout = state_r.hreadyout;
  assign hresp = state_r.hresp;
  assign hrdata = state_r.hrdata;
  assign err_flags = state_r.err_flags;
  assign pm_ctrl = state_r.pm_ctrl;

  // hsize is accepted as-is: only whole-word transfers are expected on this bank.
  logic unused_size;
  assign unused_size = ^{hsize, haddr[31:12], haddr[1:0]};

endmodule // link_status_regs

// ### tb/link_status_regs_sva.sv
// Assertion checker for the link status register bank, bound to its ports.
module link_status_regs_sva (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire link_status_pkg::err_event_t err_event,
  input wire logic [3:0] err_flags,
  input wire logic [1:0] pm_ctrl
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take;
  assign take = hsel && hready && htrans == 2'h2;
  chk_corr_set: assert property (err_event.correctable |=> err_flags[0])
    else $error("correctable flag not set");
  chk_nonfatal_set: assert property (err_event.nonfatal |=> err_flags[1])
    else $error("nonfatal flag not set");
  chk_fatal_set: assert property (err_event.fatal |=> err_flags[2])
    else $error("fatal flag not set");
  chk_unsup_set: assert property (err_event.unsupported |=> err_flags[3])
    else $error("unsupported flag not set");
  chk_flags_kept: assert property (hreadyout |=> (err_flags & $past(err_flags)) == $past(err_flags))
    else $error("flag cleared without a write");
  chk_pm_kept: assert property (hreadyout |=> $stable(pm_ctrl))
    else $error("power control changed without a write");
  chk_cap_read: assert property (take && !hwrite && haddr[11:2] == 10'h04c |-> ##2 hrdata == 32'h481)
    else $error("capability read wrong");
  chk_stat_read: assert property (take && !hwrite && haddr[11:2] == 10'h052 |-> ##2 hrdata == 32'h81)
    else $error("status read wrong");
  chk_one_wait: assert property (take |=> !hreadyout ##1 hreadyout)
    else $error("wait state count wrong");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  cover property (take && hwrite);
  cover property (take && !hwrite);
  cover property (err_event == 4'hf);
endmodule // link_status_regs_sva

bind link_status_regs link_status_regs_sva chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .err_event(err_event), .err_flags(err_flags), .pm_ctrl(pm_ctrl));

// ### tb/link_status_regs_tb.sv
// Self-checking bench for the link status register bank.
module link_status_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q, a, d;
  logic [1:0] htrans, pm_ctrl;
  logic [2:0] hsize;
  logic [3:0] err_flags, flags_m;
  logic [7:0] ctl_m;
  link_status_pkg::err_event_t err_event;
  int failures, checks_done;
  logic [31:0] addrs [5] = '{32'h128, 32'h130, 32'h140, 32'h148, 32'h1fc};
  assign hready = hreadyout;
  link_status_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .err_event(err_event),
    .err_flags(err_flags), .pm_ctrl(pm_ctrl));
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Hready is read right after the rising edge, before the bank's registers update,
  // so it is the value that edge sampled; read data is taken at the same edge.
  task automatic xfer(input logic [31:0] ad, input logic w, input logic [31:0] wd);
    htrans <= 2'h2;
    haddr <= ad;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    if (w && ad == 32'h128) flags_m = flags_m & ~wd[3:0];
    if (w && ad == 32'h140) ctl_m = wd[7:0] & 8'hc3;
  endtask
  function automatic logic [31:0] expect_rd(input logic [31:0] ad);
    case (ad)
      32'h128: return {28'h0, flags_m};
      32'h130: return 32'h0000_0481;
      32'h140: return {24'h0, ctl_m};
      32'h148: return 32'h0000_0081;
      default: return 32'h0;
    endcase
  endfunction
  task automatic read_all;
    foreach (addrs[i]) begin
      xfer(addrs[i], 1'b0, 32'h0);
      check(q, expect_rd(addrs[i]));
    end
    check({26'h0, pm_ctrl, err_flags}, {26'h0, ctl_m[1:0], flags_m});
  endtask
  initial begin
    hresetn = 1'b0; hsel = 1'b1; hsize = 3'h2; htrans = 2'h0; hwrite = 1'b0;
    haddr = 32'h0; hwdata = 32'h0; err_event = '0; flags_m = 4'h0; ctl_m = 8'h0;
    failures = 0; checks_done = 0;
    void'($urandom(29017));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    read_all();
    $display("reset values done");
    repeat (40) begin
      a = addrs[$urandom_range(4)];
      d = $urandom;
      err_event <= 4'($urandom);
      @(posedge hclk);
      flags_m = flags_m | {err_event[0], err_event[1], err_event[2], err_event[3]};
      err_event <= 4'h0;
      xfer(a, 1'b1, d);
      xfer(a, 1'b0, 32'h0);
      check(q, expect_rd(a));
      check({30'h0, pm_ctrl}, {30'h0, ctl_m[1:0]});
    end
    $display("random traffic done");
    // An event held high during a clearing write must win over the clear.
    err_event <= 4'hf;
    xfer(32'h128, 1'b1, 32'hffff_ffff);
    err_event <= 4'h0;
    flags_m = 4'hf;
    xfer(32'h128, 1'b1, 32'h0);
    read_all();
    xfer(32'h140, 1'b1, 32'hffff_ffff);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    flags_m = 4'h0;
    ctl_m = 8'h0;
    @(posedge hclk);
    read_all();
    $display("clear and reset corners done");
    end_sim();
  end
  initial begin
    #(25 * 4000);
    failures++;
    end_sim();
  end
endmodule // link_status_regs_tb
